// ==== core/bscu_shifter.sv ====
// Barrel shifter with carry-flag update, one registered stage
// Notes on behaviour
// - Serves standalone shifts and second-operand shifts
// - Zero length passes source unchanged, except for through-carry
// - Carry updates only with flag setting on a known kind; zero length blocks it except for through-carry
// - Arithmetic right fills with original sign
// - Arithmetic right carry is bit n-1
// - Arithmetic right 32+ gives all sign bits
// - Arithmetic right 32+ carry is bit 31
// - Logical right fills upper bits with zero
// - Logical right carry is bit n-1
// - Logical 32+ gives zero; 33+ carry zero
// - Logical left fills lower bits with zero
// - Left carry bit 32-n; zero leaves carry
// - Rotate right wraps low bits to top
// - Rotate right carry is bit n-1
// - Rotate by 32 keeps value, carry bit 31
// - Rotate above 32 equals length minus 32
// - Through-carry shifts one, carry into bit 31
// - Through-carry flagging sets carry from bit 0
// - Omitted shift is left by zero
module bscu_shifter (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire bscu_pkg::bscu_req_s i_req,
  output bscu_pkg::bscu_resp_s o_resp
);

  // Outputs are registered so the result lands on a clean edge; the
  // shift itself is one combinational level ahead of that flop.
  bscu_pkg::bscu_resp_s resp_reg;
  bscu_pkg::bscu_resp_s resp_next;

  logic [31:0] src;
  logic [7:0] len;
  logic [4:0] amt;
  logic [63:0] dbl;
  logic [63:0] rot_pair;
  logic sign;
  logic kind_known;

  assign src = i_req.shift_source_reg;
  assign len = i_req.length;
  assign amt = len[4:0];
  assign sign = src[bscu_pkg::SIGN_BIT];
  assign rot_pair = {src, src};

  always_comb begin
    resp_next = '0;
    dbl = '0;
    kind_known = 1'b1;
    // The source is only read here, never written back
    resp_next.result = src;
    resp_next.carry_out = i_req.carry_in;
    resp_next.to_second_operand = i_req.from_second_operand;
    unique case (i_req.kind)
      bscu_pkg::BSCU_LOGICAL_SHIFT_LEFT: begin
        if (len == bscu_pkg::LEN_ZERO) begin
          resp_next.result = src;
        end else if (len < bscu_pkg::LEN_WORD) begin
          dbl = {32'h0000_0000, src} << amt;
          resp_next.result = dbl[31:0];
          resp_next.carry_out = dbl[32];
        end else begin
          resp_next.result = '0;
          resp_next.carry_out = (len == bscu_pkg::LEN_WORD) ? src[0]
                                                            : 1'b0;
        end
      end
      bscu_pkg::BSCU_LOGICAL_SHIFT_RIGHT: begin
        if (len == bscu_pkg::LEN_ZERO) begin
          resp_next.result = src;
        end else if (len < bscu_pkg::LEN_WORD) begin
          dbl = {src, 32'h0000_0000} >> amt;
          resp_next.result = dbl[63:32];
          resp_next.carry_out = dbl[31];
        end else begin
          resp_next.result = '0;
          resp_next.carry_out = (len == bscu_pkg::LEN_WORD) ? sign : 1'b0;
        end
      end
      bscu_pkg::BSCU_ARITH_SHIFT_RIGHT: begin
        if (len == bscu_pkg::LEN_ZERO) begin
          resp_next.result = src;
        end else if (len < bscu_pkg::LEN_WORD) begin
          dbl = 64'($signed({src, 32'h0000_0000}) >>> amt);
          resp_next.result = dbl[63:32];
          resp_next.carry_out = dbl[31];
        end else begin
          resp_next.result = {32{sign}};
          resp_next.carry_out = sign;
        end
      end
      bscu_pkg::BSCU_ROTATE_RIGHT: begin
        // Past a zero length only the low five bits matter: n>=32 uses n mod 32, and 0 acts as 32
        if (len == bscu_pkg::LEN_ZERO) begin
          resp_next.result = src;
        end else if (amt == 5'h00) begin
          resp_next.result = src;
          resp_next.carry_out = sign;
        end else begin
          dbl = rot_pair >> amt;
          resp_next.result = dbl[31:0];
          resp_next.carry_out = dbl[31];
        end
      end
      bscu_pkg::BSCU_ROTATE_THROUGH_CARRY: begin
        resp_next.result = {i_req.carry_in, src[31:1]};
        resp_next.carry_out = src[0];
      end
      default: begin
        // Unknown codes pass data through and must never touch carry
        resp_next.result = src;
        kind_known = 1'b0;
      end
    endcase
    // Through-carry always moves one place, so its length never gates
    if (i_req.kind == bscu_pkg::BSCU_ROTATE_THROUGH_CARRY) begin
      resp_next.carry_update = i_req.flag_setting;
    end else begin
      resp_next.carry_update = i_req.flag_setting && kind_known &&
                               (len != bscu_pkg::LEN_ZERO);
    end
    if (!resp_next.carry_update) begin
      resp_next.carry_out = i_req.carry_in;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      resp_reg <= '0;
    end else begin
      resp_reg <= resp_next;
    end
  end

  assign o_resp = resp_reg;

  a_zero_pass: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.length == bscu_pkg::LEN_ZERO &&
     i_req.kind != bscu_pkg::BSCU_ROTATE_THROUGH_CARRY)
    |=> (o_resp.result == $past(i_req.shift_source_reg)
         && !o_resp.carry_update))
    else $error("zero length altered data or carry");

  a_left_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_LEFT &&
     i_req.length == bscu_pkg::LEN_ZERO)
    |=> (o_resp.result == $past(i_req.shift_source_reg) &&
         o_resp.carry_out == $past(i_req.carry_in)))
    else $error("omitted shift changed data or carry");

  a_carry_gate: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!i_req.flag_setting) |=> !o_resp.carry_update)
    else $error("carry updated without flag setting");

  a_carry_keep: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> (o_resp.carry_update ||
              o_resp.carry_out == $past(i_req.carry_in)))
    else $error("carry moved without an update strobe");

  a_odd_kind: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind inside {3'h4, 3'h5, 3'h7})
    |=> (o_resp.result == $past(i_req.shift_source_reg) &&
         !o_resp.carry_update))
    else $error("unknown shift kind not passed through");

  a_tag_follow: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> (o_resp.to_second_operand ==
              $past(i_req.from_second_operand)))
    else $error("second operand tag lost");

  a_asr_fill: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ARITH_SHIFT_RIGHT &&
     i_req.length == 8'h04)
    |=> o_resp.result == {{4{$past(i_req.shift_source_reg[31])}},
                          $past(i_req.shift_source_reg[31:4])})
    else $error("arithmetic shift fill wrong");

  a_asr_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ARITH_SHIFT_RIGHT &&
     i_req.length == 8'h01 && i_req.flag_setting)
    |=> o_resp.carry_out == $past(i_req.shift_source_reg[0]))
    else $error("arithmetic shift carry not bit n-1");

  a_asr_big: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ARITH_SHIFT_RIGHT &&
     i_req.length >= bscu_pkg::LEN_WORD)
    |=> o_resp.result == {32{$past(i_req.shift_source_reg[31])}})
    else $error("wide arithmetic shift not sign filled");

  a_asr_wide_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ARITH_SHIFT_RIGHT &&
     i_req.length >= bscu_pkg::LEN_WORD && i_req.flag_setting)
    |=> o_resp.carry_out == $past(i_req.shift_source_reg[31]))
    else $error("wide arithmetic shift carry not sign");

  a_lsr_fill: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_RIGHT &&
     i_req.length == 8'h01)
    |=> o_resp.result == {1'b0, $past(i_req.shift_source_reg[31:1])})
    else $error("logical right shift fill wrong");

  a_lsr_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_RIGHT &&
     i_req.length == 8'h04 && i_req.flag_setting)
    |=> (o_resp.carry_out == $past(i_req.shift_source_reg[3]) &&
         o_resp.result[31:28] == 4'h0))
    else $error("right shift carry not bit n-1");

  a_lsr_word: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_RIGHT &&
     i_req.length == bscu_pkg::LEN_WORD && i_req.flag_setting)
    |=> (o_resp.result == 32'h0000_0000 &&
         o_resp.carry_out == $past(i_req.shift_source_reg[31])))
    else $error("right shift by word wrong");

  a_lsr_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_RIGHT &&
     i_req.length >= bscu_pkg::LEN_OVER && i_req.flag_setting)
    |=> (o_resp.result == 32'h0000_0000 && !o_resp.carry_out))
    else $error("wide logical shift not cleared");

  a_lsl_wide: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_LEFT &&
     i_req.length >= bscu_pkg::LEN_OVER && i_req.flag_setting)
    |=> (o_resp.result == 32'h0000_0000 && !o_resp.carry_out))
    else $error("wide left shift not cleared");

  a_lsl_fill: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_LEFT &&
     i_req.length == 8'h04)
    |=> o_resp.result == {$past(i_req.shift_source_reg[27:0]), 4'h0})
    else $error("left shift fill wrong");

  a_lsl_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_LOGICAL_SHIFT_LEFT &&
     i_req.length == 8'h01 && i_req.flag_setting)
    |=> o_resp.carry_out == $past(i_req.shift_source_reg[31]))
    else $error("left shift carry not bit 32-n");

  a_ror_shape: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ROTATE_RIGHT &&
     i_req.length == 8'h01)
    |=> o_resp.result == {$past(i_req.shift_source_reg[0]),
                          $past(i_req.shift_source_reg[31:1])})
    else $error("rotate right shape wrong");

  a_ror_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ROTATE_RIGHT &&
     i_req.length == 8'h01 && i_req.flag_setting)
    |=> o_resp.carry_out == $past(i_req.shift_source_reg[0]))
    else $error("rotate right carry not bit n-1");

  a_ror_word: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ROTATE_RIGHT &&
     i_req.length == bscu_pkg::LEN_WORD && i_req.flag_setting)
    |=> (o_resp.result == $past(i_req.shift_source_reg) &&
         o_resp.carry_out == $past(i_req.shift_source_reg[31])))
    else $error("rotate by word wrong");

  a_ror_wrap: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ROTATE_RIGHT && i_req.length == 8'h28)
    |=> o_resp.result == {$past(i_req.shift_source_reg[7:0]),
                          $past(i_req.shift_source_reg[31:8])})
    else $error("rotate above word not reduced");

  a_rrx_shape: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ROTATE_THROUGH_CARRY &&
     i_req.flag_setting)
    |=> (o_resp.result[31] == $past(i_req.carry_in) &&
         o_resp.carry_out == $past(i_req.shift_source_reg[0]) &&
         o_resp.carry_update))
    else $error("through-carry rotate wrong");

  a_rrx_carry: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_req.kind == bscu_pkg::BSCU_ROTATE_THROUGH_CARRY &&
     i_req.length == bscu_pkg::LEN_ZERO && i_req.flag_setting)
    |=> (o_resp.carry_update &&
         o_resp.carry_out == $past(i_req.shift_source_reg[0])))
    else $error("through-carry carry gated by length");

endmodule // bscu_shifter

// ==== core/bscu_pkg.sv ====
// Shared types and constants for the barrel shifter carry unit
package bscu_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W = 8;
  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] LEN_WORD = 8'h20;
  localparam logic [7:0] LEN_OVER = 8'h21;
  localparam int unsigned SIGN_BIT = 31;

  typedef enum logic [2:0] {
    BSCU_LOGICAL_SHIFT_LEFT = 3'h0,
    BSCU_LOGICAL_SHIFT_RIGHT = 3'h1,
    BSCU_ARITH_SHIFT_RIGHT = 3'h3,
    BSCU_ROTATE_RIGHT = 3'h2,
    BSCU_ROTATE_THROUGH_CARRY = 3'h6
  } bscu_shift_e;

  typedef struct packed {
    logic [31:0] shift_source_reg;
    bscu_shift_e kind;
    logic [7:0] length;
    logic carry_in;
    logic flag_setting;
    logic from_second_operand;
  } bscu_req_s;

  typedef struct packed {
    logic [31:0] result;
    logic carry_out;
    logic carry_update;
    logic to_second_operand;
  } bscu_resp_s;
endpackage : bscu_pkg

// ==== bench/bscu_flag_model.sv ====
// Carry flag keeper standing where the condition-flag logic sits
module bscu_flag_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire bscu_pkg::bscu_resp_s i_resp,
  output logic o_carry
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only a strobed update may move the flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_carry <= 1'b0;
    end else if (i_resp.carry_update) begin
      o_carry <= i_resp.carry_out;
    end
  end
endmodule // bscu_flag_model

// ==== bench/bscu_tb_top.sv ====
// Self-checking bench for the barrel shifter carry unit
module bscu_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  bscu_pkg::bscu_req_s i_req = '0;
  bscu_pkg::bscu_resp_s o_resp;
  logic c_flag;
  logic vld = 1'b0;
  logic vld_d = 1'b0;
  bscu_pkg::bscu_resp_s q[$];
  int failures = 0;
  int comparisons = 0;
  bscu_shifter i_bscu_shifter (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_req(i_req), .o_resp(o_resp));
  bscu_flag_model i_bscu_flag_model (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_resp(o_resp), .o_carry(c_flag));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  function automatic bscu_pkg::bscu_resp_s model(bscu_pkg::bscu_req_s r);
    bscu_pkg::bscu_resp_s e;
    logic [31:0] s;
    int n;
    int m;
    s = r.shift_source_reg;
    n = r.length;
    m = n % 32;
    e.result = s;
    e.carry_out = r.carry_in;
    e.carry_update = r.flag_setting && n != 0;
    e.to_second_operand = r.from_second_operand;
    if (r.kind == bscu_pkg::BSCU_ROTATE_THROUGH_CARRY) begin
      e.result = {r.carry_in, s[31:1]};
      e.carry_out = s[0];
      e.carry_update = r.flag_setting;
    end else if (n != 0) begin
      case (r.kind)
        bscu_pkg::BSCU_LOGICAL_SHIFT_LEFT: begin
          e.result = (n >= 32) ? '0 : s << n;
          e.carry_out = (n > 32) ? 1'b0 : s[32 - n];
        end
        bscu_pkg::BSCU_LOGICAL_SHIFT_RIGHT: begin
          e.result = (n >= 32) ? '0 : s >> n;
          e.carry_out = (n > 32) ? 1'b0 : s[n - 1];
        end
        bscu_pkg::BSCU_ARITH_SHIFT_RIGHT: begin
          e.result = (n >= 32) ? {32{s[31]}}
                               : 32'($signed(s) >>> n);
          e.carry_out = (n >= 32) ? s[31] : s[n - 1];
        end
        bscu_pkg::BSCU_ROTATE_RIGHT: begin
          e.result = (m == 0) ? s
                              : (s >> m) | (s << (32 - m));
          e.carry_out = (m == 0) ? s[31] : s[m - 1];
        end
        default: e.carry_update = 1'b0;
      endcase
    end
    if (!e.carry_update) e.carry_out = r.carry_in;
    return e;
  endfunction
  task automatic chk(bscu_pkg::bscu_resp_s seen, bscu_pkg::bscu_resp_s exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t response %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic send(bscu_pkg::bscu_req_s r);
    @(posedge i_clk);
    i_req <= r;
    vld <= 1'b1;
    q.push_back(model(r));
  endtask
  // Let the last request drain before reset so no note is left stale
  task automatic reset_mid();
    @(posedge i_clk);
    vld <= 1'b0;
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    // Idle request, so the release edge, which the design ignores, is clean
    i_req <= '0;
    @(negedge i_clk);
    chk(o_resp, '0);
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask
  always @(posedge i_clk) begin
    vld_d <= vld;
  end
  always @(negedge i_clk) begin
    if (vld_d && q.size() > 0) chk(o_resp, q.pop_front());
  end
  initial begin
    #(50 * 5000);
    failures++;
    close_out();
  end
  initial begin
    bscu_pkg::bscu_req_s r;
    int lens[10] = '{0, 1, 4, 31, 32, 33, 40, 64, 255, 0};
    logic [2:0] kinds[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4};
    void'($urandom(60188));
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int p = 0; p < 40; p++) begin
      for (int k = 0; k < 6; k++) begin
        for (int j = 0; j < 10; j++) begin
          r.shift_source_reg = $urandom;
          r.kind = bscu_pkg::bscu_shift_e'(kinds[k]);
          r.length = (j == 9) ? 8'($urandom) : 8'(lens[j]);
          // Feed back the live flag, flipped at random for coverage
          r.carry_in = c_flag ^ 1'($urandom);
          r.flag_setting = 1'($urandom);
          r.from_second_operand = 1'($urandom);
          send(r);
        end
      end
      if (p == 20) reset_mid();
    end
    repeat (3) @(posedge i_clk);
    close_out();
  end
endmodule // bscu_tb_top
